//--- dv/sbt_properties.sv
// Purpose: Port-level checks for the interval timer
// Assumes: One clock, sync active-high reset
// Notes: Bound from the bench top file
`timescale 1ns/1ns
module sbt_properties
    import sbt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    // Register port and event
    input wire logic [15:0] regAddr,
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    input wire logic timerEvent
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_rd_idle;
        $past(clkEn && !regRd) |-> regRdData == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_upper;
        regRdData[31:16] == 16'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper half not zero");
    property p_ctl_unused;
        $past(clkEn && regRd && regAddr == ADDR_CONTROL) |-> (regRdData & 32'h4449) == 32'h0;
    endproperty
    a_ctl_unused: assert property (p_ctl_unused) else $error("unused bit set");
    property p_misaligned;
        $past(clkEn && regRd && regAddr[1:0] != 2'h0) |-> regRdData == 32'h0;
    endproperty
    a_misaligned: assert property (p_misaligned) else $error("misaligned read");
    property p_outside;
        $past(clkEn && regRd && regAddr > 16'h802f) |-> regRdData == 32'h0;
    endproperty
    a_outside: assert property (p_outside) else $error("unmapped read");
    property p_pulse;
        timerEvent && clkEn |=> !timerEvent [*2];
    endproperty
    a_pulse: assert property (p_pulse) else $error("event too long");
    property p_off_after_reset;
        $fell(rst) |-> !timerEvent [*3];
    endproperty
    a_off_after_reset: assert property (p_off_after_reset) else $error("event while off");
    property p_freeze;
        !clkEn |=> $stable(regRdData) && $stable(timerEvent);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
    // Main scenarios reached
    c_event: cover property (timerEvent);
    c_freeze: cover property (!clkEn);
    c_ctl_read: cover property (regRd && regAddr == ADDR_CONTROL);
endmodule

//--- dv/sbt_timer_tb.sv
// Purpose: Register-level bench for the interval timer
// Assumes: Period stays at two or more
// Notes: Event spacing is period plus one prescaled ticks
`timescale 1ns/1ns
module sbt_timer_tb;
    import sbt_pkg::*;
    // Stimulus and observed signals
    logic clk = 0, rst = 1, clkEn = 1, regWr = 0, regRd = 0, idleMode = 0, gateIn = 0;
    logic [15:0] regAddr = 16'h0;
    logic [31:0] regWrData = 32'h0, regRdData, v, w;
    logic [2:0] ext = 3'h0;
    logic timerEvent;
    int failures = 0, tests_run = 0, dv[4] = '{1, 8, 64, 256};
    sbt_timer dut (.clk(clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .idleMode(idleMode), .secondaryOscillator(ext[0]), .externalTimerClockPin(ext[1]),
        .lowPowerRcOscillator(ext[2]), .gateIn(gateIn), .timerEvent(timerEvent));
    initial forever #2 clk = ~clk;
    // Counts, verdict, end of run
    task give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // One-cycle write strobe
    task wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 0;
    endtask
    // Read, data left in v from the cycle after the strobe
    task rd(input logic [15:0] a);
        @(posedge clk);
        regRd <= 1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 0;
        #1 v = regRdData;
    endtask
    // Read and compare against the expected value
    task rc(input logic [15:0] a, input logic [31:0] e, input string n);
        rd(a);
        chk(n, v, e);
    endtask
    // Whether the count changes over five cycles
    task moving(input logic m);
        rd(ADDR_COUNT);
        chk("count upper", v & 32'hffff0000, 32'h0);
        w = v;
        repeat (3) @(posedge clk);
        rd(ADDR_COUNT);
        chk("count upper", v & 32'hffff0000, 32'h0);
        chk("count moved", {31'h0, v !== w}, {31'h0, m});
    endtask
    // Cycles between two events, bounded
    task gap(input int e);
        int c;
        repeat (2)
        begin
            c = 0;
            do
            begin
                @(posedge clk);
                #1 c++;
            end while (timerEvent !== 1'b1 && c < 3000);
        end
        chk("event gap", c, e);
        if (c >= 3000)
            give_verdict;
    endtask
    // Two back-to-back count writes, then pending flag and final count
    task pend(input logic [31:0] ctl, input logic [31:0] ep, input logic [31:0] ec);
        wr(ADDR_CONTROL, ctl);
        @(posedge clk);
        regWr <= 1;
        regAddr <= ADDR_COUNT;
        regWrData <= 32'h1234;
        @(posedge clk);
        regWrData <= 32'h5555;
        @(posedge clk);
        regWr <= 0;
        regRd <= 1;
        regAddr <= ADDR_CONTROL;
        @(posedge clk);
        regRd <= 0;
        #1 chk("pending", regRdData & 32'h800, ep);
        repeat (5) @(posedge clk);
        rc(ADDR_COUNT, ec, "count after write");
    endtask
    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 0;
        rc(ADDR_CONTROL, 32'h0, "control reset");
        rc(ADDR_COUNT, 32'h0, "count reset");
        rc(ADDR_PERIOD, 32'hffff, "period reset");
        wr(ADDR_CONTROL, 32'hffffffff);
        rc(ADDR_CONTROL, 32'hb3b6, "control mask");
        rc(16'h8002, 32'h0, "misaligned");
        wr(ADDR_PERIOD, 32'hf0);
        wr(ADDR_PERIOD + ALIAS_CLR, 32'h30);
        wr(ADDR_PERIOD + ALIAS_SET, 32'h5);
        wr(ADDR_PERIOD + ALIAS_INV, 32'hff);
        rc(ADDR_PERIOD, 32'h3a, "alias result");
        $display("register test done");
        wr(ADDR_CONTROL, 32'h0);
        wr(ADDR_PERIOD, 32'h5);
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_CONTROL, 32'h8000 | (i << 4));
            gap(6 * dv[i]);
        end
        $display("prescale test done");
        wr(ADDR_PERIOD, 32'h64);
        wr(ADDR_CONTROL + ALIAS_CLR, 32'h8030);
        moving(0);
        wr(ADDR_CONTROL + ALIAS_SET, 32'ha000);
        idleMode <= 1;
        moving(0);
        wr(ADDR_CONTROL + ALIAS_CLR, 32'h2000);
        moving(1);
        wr(ADDR_CONTROL + ALIAS_SET, 32'h80);
        idleMode <= 0;
        moving(0);
        @(posedge clk);
        gateIn <= 1;
        clkEn <= 0;
        repeat (3) @(posedge clk);
        clkEn <= 1;
        moving(1);
        $display("enable test done");
        for (int i = 0; i < 3; i++)
        begin
            wr(ADDR_CONTROL, 32'h8086 | (i << 8));
            wr(ADDR_COUNT, 32'h0);
            repeat (8) @(posedge clk) ext[i] <= ~ext[i];
            repeat (4) @(posedge clk);
            rc(ADDR_COUNT, 32'h4, "external ticks");
        end
        $display("source test done");
        pend(32'h9102, 32'h800, 32'h1234);
        rc(ADDR_CONTROL, 32'h9102, "pending cleared");
        pend(32'h8102, 32'h800, 32'h5555);
        pend(32'h9106, 32'h0, 32'h5555);
        $display("write test done");
        give_verdict;
    end
endmodule
bind sbt_timer sbt_properties chk (.clk(clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
    .regRd(regRd), .regRdData(regRdData), .timerEvent(timerEvent));

//--- rtl/sbt_pkg.sv
// Purpose: Constants for the 16-bit interval timer
// Assumes: 32-bit register port, byte addresses
// Notes: Alias offsets are added to each register's base
package sbt_pkg;
    // Register byte addresses
    localparam logic [15:0] ADDR_CONTROL = 16'h8000;
    localparam logic [15:0] ADDR_COUNT = 16'h8010;
    localparam logic [15:0] ADDR_PERIOD = 16'h8020;
    // Alias offsets: plain, clear, set, invert
    localparam logic [3:0] ALIAS_PLAIN = 4'h0;
    localparam logic [3:0] ALIAS_CLR = 4'h4;
    localparam logic [3:0] ALIAS_SET = 4'h8;
    localparam logic [3:0] ALIAS_INV = 4'hc;
    // Control field positions
    localparam int BIT_ON = 15;
    localparam int BIT_STOP_IN_IDLE = 13;
    localparam int BIT_WDIS = 12;
    localparam int BIT_WIP = 11;
    localparam int BIT_ECS_LO = 8;
    localparam int BIT_GATE = 7;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_SYNC = 2;
    localparam int BIT_CS = 1;
    // Writable control bits (status bit and unused bits excluded)
    localparam logic [15:0] CONTROL_WMASK = 16'hb3b6;
    // Reset values
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hffff;
    // External source codes
    localparam logic [1:0] ECS_SECONDARY_OSCILLATOR = 2'h0;
    localparam logic [1:0] ECS_PIN = 2'h1;
    localparam logic [1:0] ECS_LOW_POWER_RC_OSCILLATOR = 2'h2;
    // Prescale terminal counts (divide minus one)
    localparam logic [7:0] PS_DIV1 = 8'h00;
    localparam logic [7:0] PS_DIV8 = 8'h07;
    localparam logic [7:0] PS_DIV64 = 8'h3f;
    localparam logic [7:0] PS_DIV256 = 8'hff;
    // Cycles an asynchronous count write stays in flight
    localparam logic [1:0] ASYNC_WRITE_CYCLES = 2'h3;
endpackage

//--- rtl/sbt_timer.sv
// Purpose: 16-bit interval timer with clear/set/invert register aliases
// Assumes: All inputs synchronous to clk; external sources arrive as levels
// Notes: Event pulse marks each period match rollover
//
// Operation
// - Count only while enable bit set
// - Stop-in-idle halts timer during idle mode
// - Write-block ignores count writes while pending
// - Pending flag set during async count write
// - Selection field picks external count source
// - Gate enable honoured only with bus clock
// - Prescaler divides by 1, 8, 64, 256
// - Clear, set, invert aliases per register
// - Unused bits read zero, ignore writes
//
// Design decision made here: strobed register access.
`timescale 1ns/1ns
module sbt_timer
    import sbt_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    // Register port
    input wire logic [15:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // Device state and count sources
    input wire logic idleMode,
    input wire logic secondaryOscillator,
    input wire logic externalTimerClockPin,
    input wire logic lowPowerRcOscillator,
    input wire logic gateIn,
    // Timer event
    output logic timerEvent
);
    // Registers
    logic [15:0] timerControl;
    logic [15:0] timerCount;
    logic [15:0] timerPeriod;
    logic [7:0] prescaleCount;
    logic srcPrev; // Previous level of selected external source
    logic srcSync1; // First resync stage
    logic srcSync2; // Second resync stage
    logic [1:0] pendCount; // Async write in flight
    logic [15:0] pendData; // Value being transferred

    // Register window layout
    // Each register sits on a 16-byte slot: plain, clear, set, invert
    // Only the low half of the 32-bit word is implemented
    // Upper half always reads zero and drops writes
    // Low address bits 1:0 must be zero or the access is ignored
    // Unmapped slots read zero and ignore writes
    //
    // Counting model
    // A qualified tick feeds the prescaler
    // The prescaler terminal count releases one count step
    // The count wraps to zero after matching the period
    // The wrap raises a one-cycle event pulse
    // Period values zero and one are for software to avoid

    // Alias write merge
    function automatic logic [15:0] alias_merge(input logic [15:0] cur,
        input logic [15:0] wd, input logic [3:0] kind);
        logic [15:0] res;
        res = cur;
        case (kind)
            ALIAS_PLAIN: res = wd;
            ALIAS_CLR: res = cur & ~wd;
            ALIAS_SET: res = cur | wd;
            ALIAS_INV: res = cur ^ wd;
            default: res = cur;
        endcase
        return res;
    endfunction

    // Address decode
    // Slot base compared with low nibble masked off
    // Low nibble picks plain, clear, set or invert action
    // Misaligned nibbles fail the alignment check
    // Hazard: a misaligned write must not reach any register
    // Alignment check covers reads and writes alike
    wire [3:0] aliasKind = regAddr[3:0];
    wire [15:0] regBase = {regAddr[15:4], 4'h0};
    wire aliasOk = (aliasKind[1:0] == 2'b00);
    wire hitCtrl = aliasOk && (regBase == ADDR_CONTROL);
    wire hitCount = aliasOk && (regBase == ADDR_COUNT);
    wire hitPeriod = aliasOk && (regBase == ADDR_PERIOD);

    // Control fields
    wire ctlOn = timerControl[BIT_ON];
    wire ctlSidl = timerControl[BIT_STOP_IN_IDLE];
    wire ctlWdis = timerControl[BIT_WDIS];
    wire [1:0] ctlEcs = timerControl[BIT_ECS_LO +: 2];
    wire ctlGate = timerControl[BIT_GATE];
    wire [1:0] ctlPs = timerControl[BIT_PS_LO +: 2];
    wire ctlSync = timerControl[BIT_SYNC];
    wire ctlCs = timerControl[BIT_CS];
    wire asyncMode = ctlCs && !ctlSync;
    wire writePending = asyncMode && (pendCount != 2'h0);

    // External source select; reserved code gives no edges
    logic extSrc;
    always_comb
    begin
        case (ctlEcs)
            ECS_SECONDARY_OSCILLATOR: extSrc = secondaryOscillator;
            ECS_PIN: extSrc = externalTimerClockPin;
            ECS_LOW_POWER_RC_OSCILLATOR: extSrc = lowPowerRcOscillator;
            default: extSrc = 1'b0;
        endcase
    end

    // Edge of resynced or direct external source
    wire srcLevel = ctlSync ? srcSync2 : extSrc;
    wire extEdge = srcLevel && !srcPrev;

    // Tick input: bus clock every cycle, gated only in bus-clock mode
    wire running = ctlOn && !(ctlSidl && idleMode);
    wire rawTick = ctlCs ? extEdge : (!ctlGate || gateIn);

    // Prescaler terminal count
    logic [7:0] psTerm;
    always_comb
    begin
        case (ctlPs)
            2'h0: psTerm = PS_DIV1;
            2'h1: psTerm = PS_DIV8;
            2'h2: psTerm = PS_DIV64;
            default: psTerm = PS_DIV256;
        endcase
    end
    wire psDone = running && rawTick && (prescaleCount >= psTerm);
    wire periodMatch = (timerCount == timerPeriod);

    // Count write handling
    wire countWr = regWr && hitCount;
    wire countWrTaken = countWr && !(ctlWdis && writePending);
    wire [15:0] countWrVal = alias_merge(timerCount, regWrData[15:0], aliasKind);

    // Read mux; upper half and unused bits read zero
    logic [15:0] rdSel;
    always_comb
    begin
        rdSel = 16'h0000;
        if (hitCtrl)
        begin
            rdSel = timerControl & CONTROL_WMASK;
            rdSel[BIT_WIP] = writePending;
        end
        else if (hitCount)
        begin
            rdSel = timerCount;
        end
        else if (hitPeriod)
        begin
            rdSel = timerPeriod;
        end
    end

    // Control and period registers
    // Write mask keeps the status bit and unused bits at zero
    // Alias merge applied before the mask
    // Period accepts any value; software keeps it at two or more
    // Frozen along with everything else while clkEn is low
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            timerControl <= CONTROL_RESET;
            timerPeriod <= PERIOD_RESET;
        end
        else if (clkEn && regWr)
        begin
            if (hitCtrl)
                timerControl <= alias_merge(timerControl, regWrData[15:0], aliasKind)
                    & CONTROL_WMASK;
            if (hitPeriod)
                timerPeriod <= alias_merge(timerPeriod, regWrData[15:0], aliasKind);
        end
    end

    // Source edge tracking
    // Two-stage resync only read through its second stage
    // Previous level tracks whichever path is selected
    // Reset level low so a low source gives no false edge
    // Switching the resync bit may cost or add one edge
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            srcSync1 <= 1'b0;
            srcSync2 <= 1'b0;
            srcPrev <= 1'b0;
        end
        else if (clkEn)
        begin
            srcSync1 <= extSrc;
            srcSync2 <= srcSync1;
            srcPrev <= srcLevel;
        end
    end

    // Async write transfer tracker
    // Models the crossing of a count write into the external domain
    // Counter loaded on a taken write, counts down to zero
    // Pending flag reads high while the counter is nonzero
    // With write-block clear a new write restarts the transfer
    // With write-block set writes during transfer are dropped
    // Synchronous mode never loads the counter
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pendCount <= 2'h0;
            pendData <= COUNT_RESET;
        end
        else if (clkEn)
        begin
            if (countWrTaken && asyncMode)
            begin
                pendCount <= ASYNC_WRITE_CYCLES;
                pendData <= countWrVal;
            end
            else if (pendCount != 2'h0)
                pendCount <= pendCount - 2'h1;
        end
    end

    // Prescaler and counter
    // Write priority: direct write, then finished async write, then tick
    // A write does not clear the prescaler
    // Prescaler cleared while disabled so restart is clean
    // Idle stop holds the prescaler value rather than clearing it
    // Event pulse is registered and lasts one enabled cycle
    // Count equal to period at a step wraps to zero
    // A count above the period runs up to wrap at all ones
    // Hazard: period below two would pulse too often
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prescaleCount <= 8'h00;
            timerCount <= COUNT_RESET;
            timerEvent <= 1'b0;
        end
        else if (clkEn)
        begin
            timerEvent <= 1'b0;
            if (countWrTaken && !asyncMode)
                timerCount <= countWrVal;
            else if (asyncMode && pendCount == 2'h1)
                timerCount <= pendData;
            else if (psDone)
            begin
                if (periodMatch)
                begin
                    timerCount <= 16'h0000;
                    timerEvent <= 1'b1;
                end
                else
                    timerCount <= timerCount + 16'h0001;
            end
            if (!ctlOn)
                prescaleCount <= 8'h00;
            else if (psDone)
                prescaleCount <= 8'h00;
            else if (running && rawTick)
                prescaleCount <= prescaleCount + 8'h01;
        end
    end

    // Read data one cycle after strobe
    // Zero in every enabled cycle without a read strobe
    // Holds its value while clkEn is low
    // No wait states: the slave always answers in one cycle
    // Upper half driven as constant zero
    always_ff @(posedge clk)
    begin
        if (rst)
            regRdData <= 32'h0000_0000;
        else if (clkEn)
            regRdData <= regRd ? {16'h0000, rdSel} : 32'h0000_0000;
    end
endmodule
